// >>> design/nce_ctrl.sv
// host controller driving a two-plane nand device over its strobed pins
// Function
// R1 - page read sends 00h, five address bytes, then 30h
// R2 - device loads whole page, shows busy on ready/busy until done
// R3 - one byte per read strobe falling edge, sequential from column
// R4 - random data output with new column continues from that column
// R5 - each page programmed once, pages of a block in ascending order; the code checks only against the last programmed page
// R6 - program load is 80h, five address bytes, up to 2112 data bytes
// R7 - 85h plus column moves the input pointer during loading
// R8 - 10h starts programming only after serial data was loaded
// R9 - while busy only status read and reset are allowed
// R10 - completion on ready/busy and status bit 6, result on bit 0
// R11 - verify flags only bits that failed to go from 1 to 0
// R12 - after program the device keeps returning status on each read
// R13 - copy-back is 35h plus source, 85h plus destination, then 10h
// R14 - copy-back source and destination lie in the same plane
// R15 - random data input may modify buffered bytes during copy-back
// R16 - erase is 60h, three row bytes, then D0h; result on bit 0
// R17 - two-plane ops accept unaligned blocks with identical page address; the code refuses a second-plane program row differing in more than the plane bit
// R18 - two-plane program: first plane, 11h, 81h second plane, 10h
// R19 - between 11h and 81h only 70h or FFh may be sent
// R20 - two-plane program reports one combined fail on bit 0
// R21 - both two-plane blocks share the row except the plane bit; for two-plane erase the code checks only that the plane bit differs
// R22 - two-plane erase repeats 60h with address per plane, then D0h
// R23 - after 70h each read gives status: ready, fail, not protected
// R24 - ready/busy low from confirm until the operation ends
`timescale 1ns/1ns
`include "nce_map.svh"
module nce_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire nce_pkg::nce_req_s req,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic busy,
  output logic done,
  output logic fail,
  output logic refused,
  output logic [7:0] status,
  output nce_pkg::nce_pins_s nand_o,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);
  localparam nce_pkg::nce_ctl_s CTL_RST = '{
    st: nce_pkg::ST_IDLE,
    pins: '{ce_n: 1'b1, we_n: 1'b1, read_strobe_n: 1'b1, io_oe_n: 1'b1, default: '0},
    default: '0
  };

  nce_pkg::nce_ctl_s q;
  nce_pkg::nce_ctl_s n;
  logic buf_in_valid;
  logic buf_in_ready;
  logic wr_st;
  logic adv;
  logic [7:0] wb;
  logic wc;
  logic wa;
  nce_pkg::nce_plan_s pl;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic nce_pkg::nce_plan_s plan_of(input nce_pkg::nce_op_e op);
    nce_pkg::nce_plan_s p;
    p = '0;
    p.naddr = 3'h5;
    case (op)
      nce_pkg::OP_READ: begin
        p.cmd1 = `NCE_CMD_READ1; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_READ2; p.wait_b = 1'b1; p.rd = 1'b1; // R1
      end
      nce_pkg::OP_ROUT: begin
        p.cmd1 = `NCE_CMD_ROUT1; p.naddr = 3'h2; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_ROUT2; p.rd = 1'b1; // R4
      end
      nce_pkg::OP_CBREAD: begin
        p.cmd1 = `NCE_CMD_READ1; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_CBREAD; p.wait_b = 1'b1; // R13
      end
      nce_pkg::OP_PROG: begin
        p.cmd1 = `NCE_CMD_LOAD; p.wr = 1'b1; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_CONF; // R6
        p.wait_b = 1'b1; p.stat = 1'b1;
      end
      nce_pkg::OP_PROG_P1: begin
        p.cmd1 = `NCE_CMD_LOAD; p.wr = 1'b1; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_DCONF; p.wait_b = 1'b1; // R18
      end
      nce_pkg::OP_PROG_P2, nce_pkg::OP_CB_P2: begin
        p.cmd1 = `NCE_CMD_LOAD2; p.wr = 1'b1; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_CONF; // R18
        p.wait_b = 1'b1; p.stat = 1'b1;
      end
      nce_pkg::OP_CBPROG: begin
        p.cmd1 = `NCE_CMD_RIN; p.wr = 1'b1; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_CONF; // R13
        p.wait_b = 1'b1; p.stat = 1'b1;
      end
      nce_pkg::OP_CB_P1: begin
        p.cmd1 = `NCE_CMD_RIN; p.wr = 1'b1; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_DCONF; p.wait_b = 1'b1;
      end
      nce_pkg::OP_RIN: begin
        p.cmd1 = `NCE_CMD_RIN; p.naddr = 3'h2; p.wr = 1'b1; // R7 R15
      end
      nce_pkg::OP_ERASE: begin
        p.cmd1 = `NCE_CMD_ERASE1; p.naddr = 3'h3; p.has2 = 1'b1; p.cmd2 = `NCE_CMD_ERASE2; // R16
        p.wait_b = 1'b1; p.stat = 1'b1;
      end
      nce_pkg::OP_ERASE_P1: begin
        p.cmd1 = `NCE_CMD_ERASE1; p.naddr = 3'h3; // R22
      end
      nce_pkg::OP_STATUS: begin
        p.skip1 = 1'b1; p.naddr = 3'h0; p.stat = 1'b1; // R23
      end
      nce_pkg::OP_RESET: begin
        p.cmd1 = `NCE_CMD_RESET; p.naddr = 3'h0; p.wait_b = 1'b1;
      end
      default: begin
        p.skip1 = 1'b1; p.naddr = 3'h0; p.stat = 1'b1;
      end
    endcase
    return p;
  endfunction

  function automatic logic [7:0] addr_byte(input logic [2:0] i, input nce_pkg::nce_req_s r);
    case (i)
      3'h0: return r.col[7:0];
      3'h1: return {4'h0, r.col[11:8]};
      3'h2: return r.row[7:0];
      3'h3: return r.row[15:8];
      default: return {7'h00, r.row[16]};
    endcase
  endfunction

  function automatic logic refuse(input nce_pkg::nce_req_s r, input nce_pkg::nce_ctl_s s);
    logic bad;
    logic is_p2;
    logic is_prog;
    logic pass;
    bad = 1'b0;
    is_p2 = (r.op == nce_pkg::OP_PROG_P2) || (r.op == nce_pkg::OP_CB_P2);
    is_prog = (r.op == nce_pkg::OP_PROG) || (r.op == nce_pkg::OP_PROG_P1) || (r.op == nce_pkg::OP_CBPROG) ||
              (r.op == nce_pkg::OP_CB_P1);
    pass = (r.op == nce_pkg::OP_STATUS) || (r.op == nce_pkg::OP_RESET);
    if (s.plane_pend && !pass && !is_p2) bad = 1'b1; // R19
    if (!s.plane_pend && is_p2) bad = 1'b1; // R18
    if (is_p2 && ((r.row ^ s.p1_row) != (17'h0_0001 << `NCE_PLANE_BIT))) bad = 1'b1; // R21 R17
    if (s.erase_pend && !pass && (r.op != nce_pkg::OP_ERASE)) bad = 1'b1; // R22
    if (s.erase_pend && (r.op == nce_pkg::OP_ERASE) && (r.row[`NCE_PLANE_BIT] == s.p1_row[`NCE_PLANE_BIT]))
      bad = 1'b1; // R22
    if (((r.op == nce_pkg::OP_PROG) || (r.op == nce_pkg::OP_PROG_P1) || (r.op == nce_pkg::OP_PROG_P2)) &&
        (r.len == 12'h000)) bad = 1'b1; // R8
    if (r.len > `NCE_PAGE_BYTES) bad = 1'b1; // R6
    if (((r.op == nce_pkg::OP_CBPROG) || (r.op == nce_pkg::OP_CB_P1)) &&
        (r.row[`NCE_PLANE_BIT] != s.cb_plane)) bad = 1'b1; // R14
    if (is_prog && s.last_v && (r.row[16:`NCE_PAGE_W] == s.last_row[16:`NCE_PAGE_W]) &&
        (r.row[`NCE_PAGE_W-1:0] <= s.last_row[`NCE_PAGE_W-1:0])) bad = 1'b1; // R5
    return bad;
  endfunction

  // ----------------------------------------
  // read buffer
  // ----------------------------------------
  nce_buf2 #(
    .W(8)
  ) u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(q.io2),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign req_ready = (q.st == nce_pkg::ST_IDLE);
  assign busy = (q.st != nce_pkg::ST_IDLE);
  assign wr_ready = (q.st == nce_pkg::ST_DATA_W) && !q.ph;
  assign done = q.done;
  assign fail = q.fail;
  assign refused = q.refused;
  assign status = q.status;
  assign nand_o = q.pins;

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.refused = 1'b0;
    n.rb1 = rb_n;
    n.rb2 = q.rb1;
    n.io1 = io_in;
    n.io2 = q.io1;
    buf_in_valid = 1'b0;
    adv = 1'b0;
    pl = plan_of(req.op);
    wb = 8'h00;
    wc = 1'b0;
    wa = 1'b0;
    case (q.st)
      nce_pkg::ST_CMD1: begin wb = q.plan.cmd1; wc = 1'b1; end
      nce_pkg::ST_ADDR: begin wb = addr_byte(q.aidx, q.req); wa = 1'b1; end
      nce_pkg::ST_CMD2: begin wb = q.plan.cmd2; wc = 1'b1; end
      nce_pkg::ST_STAT_CMD: begin wb = `NCE_CMD_STATUS; wc = 1'b1; end
      default: wb = wr_data;
    endcase
    wr_st = (q.st == nce_pkg::ST_CMD1) || (q.st == nce_pkg::ST_ADDR) || (q.st == nce_pkg::ST_CMD2) ||
            (q.st == nce_pkg::ST_STAT_CMD) || ((q.st == nce_pkg::ST_DATA_W) && (q.ph || wr_valid));
    if (wr_st) begin
      if (!q.ph) begin
        n.pins.we_n = 1'b0;
        n.pins.io_out = wb;
        n.pins.cle = wc;
        n.pins.ale = wa;
        n.pins.io_oe_n = 1'b0;
        n.ph = 1'b1;
      end else begin
        n.pins.we_n = 1'b1;
        n.ph = 1'b0;
        adv = 1'b1;
      end
    end
    if ((q.st == nce_pkg::ST_DATA_R) || (q.st == nce_pkg::ST_STAT_RD)) begin
      n.pins.cle = 1'b0;
      n.pins.ale = 1'b0;
      if (!q.ph) begin
        if ((q.st == nce_pkg::ST_STAT_RD) || buf_in_ready) begin
          n.pins.read_strobe_n = 1'b0; // R3
          n.pins.io_oe_n = 1'b1;
          n.cnt = 4'(`NCE_STB_LO - 1);
          n.ph = 1'b1;
        end
      end else if (q.cnt != 4'h0) begin
        n.cnt = q.cnt - 4'h1;
      end else begin
        n.pins.read_strobe_n = 1'b1;
        n.ph = 1'b0;
        adv = 1'b1;
      end
    end
    case (q.st)
      nce_pkg::ST_IDLE: begin
        n.pins.ce_n = 1'b1;
        n.pins.wp_n = 1'b1;
        n.pins.io_oe_n = 1'b1;
        n.pins.cle = 1'b0;
        n.pins.ale = 1'b0;
        if (req_valid) begin // R9
          if (refuse(req, q)) begin
            n.refused = 1'b1;
          end else begin
            n.req = req;
            n.plan = pl;
            n.left = req.len;
            n.aidx = (pl.naddr == 3'h3) ? 3'h2 : 3'h0;
            n.ph = 1'b0;
            n.pins.ce_n = 1'b0;
            n.st = pl.skip1 ? nce_pkg::ST_STAT_CMD : nce_pkg::ST_CMD1;
            case (req.op)
              nce_pkg::OP_PROG_P1, nce_pkg::OP_CB_P1: begin n.plane_pend = 1'b1; n.p1_row = req.row; end
              nce_pkg::OP_PROG_P2, nce_pkg::OP_CB_P2: n.plane_pend = 1'b0;
              nce_pkg::OP_ERASE_P1: begin n.erase_pend = 1'b1; n.p1_row = req.row; end
              nce_pkg::OP_ERASE: begin n.erase_pend = 1'b0; n.last_v = 1'b0; end
              nce_pkg::OP_CBREAD: n.cb_plane = req.row[`NCE_PLANE_BIT];
              nce_pkg::OP_RESET: begin n.plane_pend = 1'b0; n.erase_pend = 1'b0; end
              default: n.plane_pend = q.plane_pend;
            endcase
            if ((req.op == nce_pkg::OP_PROG) || (req.op == nce_pkg::OP_PROG_P1) ||
                (req.op == nce_pkg::OP_CBPROG) || (req.op == nce_pkg::OP_CB_P1)) begin
              n.last_v = 1'b1; // R5
              n.last_row = req.row;
            end
          end
        end
      end
      nce_pkg::ST_CMD1: begin
        if (adv) n.st = (q.plan.naddr != 3'h0) ? nce_pkg::ST_ADDR : nce_pkg::ST_WB;
        if (adv) n.cnt = 4'(`NCE_WB_CYC);
      end
      nce_pkg::ST_ADDR: begin
        if (adv) begin
          n.aidx = q.aidx + 3'h1;
          if (q.aidx == ((q.plan.naddr == 3'h2) ? 3'h1 : 3'h4)) begin
            if (q.plan.wr && (q.left != 12'h000)) begin
              n.st = nce_pkg::ST_ADL;
              n.cnt = 4'(`NCE_ADL_CYC);
            end else begin
              n.st = q.plan.has2 ? nce_pkg::ST_CMD2 : nce_pkg::ST_DONE;
            end
          end
        end
      end
      nce_pkg::ST_ADL: begin
        if (q.cnt != 4'h0) n.cnt = q.cnt - 4'h1;
        else n.st = nce_pkg::ST_DATA_W;
      end
      nce_pkg::ST_DATA_W: begin
        if (adv) begin
          n.left = q.left - 12'h001; // R6 R7
          if (q.left == 12'h001) n.st = q.plan.has2 ? nce_pkg::ST_CMD2 : nce_pkg::ST_DONE; // R8
        end
      end
      nce_pkg::ST_CMD2: begin
        if (adv) begin
          n.st = nce_pkg::ST_WB; // R16
          n.cnt = 4'(`NCE_WB_CYC);
        end
      end
      nce_pkg::ST_WB: begin
        if (q.cnt != 4'h0) n.cnt = q.cnt - 4'h1;
        else if (q.plan.wait_b) n.st = nce_pkg::ST_BUSY;
        else n.st = (q.plan.rd && (q.left != 12'h000)) ? nce_pkg::ST_DATA_R : nce_pkg::ST_DONE;
      end
      nce_pkg::ST_BUSY: begin
        if (q.rb2) begin // R2 R24 R10
          if (q.plan.rd && (q.left != 12'h000)) n.st = nce_pkg::ST_DATA_R;
          else n.st = q.plan.stat ? nce_pkg::ST_STAT_CMD : nce_pkg::ST_DONE;
        end
      end
      nce_pkg::ST_DATA_R: begin
        if (adv) begin
          buf_in_valid = 1'b1; // R3
          n.left = q.left - 12'h001;
          if (q.left == 12'h001) n.st = nce_pkg::ST_DONE;
        end
      end
      nce_pkg::ST_STAT_CMD: begin
        if (adv) n.st = nce_pkg::ST_STAT_RD;
      end
      nce_pkg::ST_STAT_RD: begin
        if (adv) begin
          n.status = q.io2; // R12 R23
          if (q.io2[`NCE_ST_READY]) begin
            n.fail = q.io2[`NCE_ST_FAIL]; // R10 R20
            n.st = nce_pkg::ST_DONE;
          end
        end
      end
      nce_pkg::ST_DONE: begin
        n.pins.ce_n = 1'b1;
        n.pins.io_oe_n = 1'b1;
        n.pins.cle = 1'b0;
        n.pins.ale = 1'b0;
        n.done = 1'b1;
        n.st = nce_pkg::ST_IDLE;
      end
      default: n.st = nce_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= CTL_RST;
    end else begin
      q <= n;
    end
  end
endmodule

// >>> common/nce_map.svh
// constants of the nand command engine controller
`ifndef NCE_MAP_SVH
`define NCE_MAP_SVH

// ----------------------------------------
// command bytes
// ----------------------------------------
`define NCE_CMD_READ1 8'h00
`define NCE_CMD_READ2 8'h30
`define NCE_CMD_CBREAD 8'h35
`define NCE_CMD_ROUT1 8'h05
`define NCE_CMD_ROUT2 8'hE0
`define NCE_CMD_LOAD 8'h80
`define NCE_CMD_LOAD2 8'h81
`define NCE_CMD_RIN 8'h85
`define NCE_CMD_CONF 8'h10
`define NCE_CMD_DCONF 8'h11
`define NCE_CMD_ERASE1 8'h60
`define NCE_CMD_ERASE2 8'hD0
`define NCE_CMD_STATUS 8'h70
`define NCE_CMD_RESET 8'hFF

// ----------------------------------------
// fields
// ----------------------------------------
`define NCE_ST_FAIL 0
`define NCE_ST_READY 6
`define NCE_ST_NOWP 7
`define NCE_PLANE_BIT 6
`define NCE_PAGE_W 6
`define NCE_PAGE_BYTES 12'h0840

// ----------------------------------------
// timing
// ----------------------------------------
`define NCE_CLK_NS 100
`define NCE_WB_NS 100
`define NCE_ADL_NS 70
`define NCE_CYC(ns) (((ns) + `NCE_CLK_NS - 1) / `NCE_CLK_NS)
`define NCE_WB_CYC `NCE_CYC(`NCE_WB_NS)
`define NCE_ADL_CYC `NCE_CYC(`NCE_ADL_NS)
`define NCE_STB_LO 3

`endif

// >>> common/nce_pkg.sv
// types of the nand command engine controller
package nce_pkg;

  // ----------------------------------------
  // operations and states
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_ROUT = 4'h1, OP_CBREAD = 4'h2, OP_PROG = 4'h3,
    OP_PROG_P1 = 4'h4, OP_PROG_P2 = 4'h5, OP_CBPROG = 4'h6, OP_CB_P1 = 4'h7,
    OP_CB_P2 = 4'h8, OP_RIN = 4'h9, OP_ERASE = 4'hA, OP_ERASE_P1 = 4'hB,
    OP_STATUS = 4'hC, OP_RESET = 4'hD
  } nce_op_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_CMD1 = 4'h1, ST_ADDR = 4'h2, ST_ADL = 4'h3, ST_DATA_W = 4'h4,
    ST_CMD2 = 4'h5, ST_WB = 4'h6, ST_BUSY = 4'h7, ST_DATA_R = 4'h8,
    ST_STAT_CMD = 4'h9, ST_STAT_RD = 4'hA, ST_DONE = 4'hB
  } nce_state_e;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    nce_op_e op;
    logic [11:0] col;
    logic [16:0] row;
    logic [11:0] len;
  } nce_req_s;

  typedef struct packed {
    logic skip1;
    logic [7:0] cmd1;
    logic [2:0] naddr;
    logic wr;
    logic has2;
    logic [7:0] cmd2;
    logic wait_b;
    logic rd;
    logic stat;
  } nce_plan_s;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic io_oe_n;
    logic [7:0] io_out;
  } nce_pins_s;

  typedef struct packed {
    nce_state_e st;
    logic ph;
    logic [3:0] cnt;
    logic [2:0] aidx;
    logic [11:0] left;
    nce_req_s req;
    nce_plan_s plan;
    nce_pins_s pins;
    logic rb1;
    logic rb2;
    logic [7:0] io1;
    logic [7:0] io2;
    logic [7:0] status;
    logic done;
    logic fail;
    logic refused;
    logic plane_pend;
    logic erase_pend;
    logic [16:0] p1_row;
    logic cb_plane;
    logic last_v;
    logic [16:0] last_row;
  } nce_ctl_s;

endpackage

// >>> design/nce_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module nce_buf2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } nce_buf_s;

  nce_buf_s q;
  nce_buf_s n;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp = ~q.wp;
    end
    if (pop) begin
      n.rp = ~q.rp;
    end
    n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// >>> tb/nce_ctrl_properties.sv
// concurrent checks on controller ports
`timescale 1ns/1ns
module nce_ctrl_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [7:0] rd_data,
  input wire logic done,
  input wire logic fail,
  input wire logic refused,
  input wire nce_pkg::nce_pins_s nand_o,
  input wire logic rb_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // pin protocol
  // ----------------------------------------
  cmd_cycle_a: assert property (
    nand_o.cle && !nand_o.we_n |-> !nand_o.ale && !nand_o.io_oe_n && !nand_o.ce_n)
    else $error("bad command cycle");
  addr_cycle_a: assert property (
    nand_o.ale && !nand_o.we_n |-> !nand_o.cle && !nand_o.io_oe_n)
    else $error("bad address cycle");
  write_pulse_a: assert property (
    $fell(nand_o.we_n) |=> $rose(nand_o.we_n))
    else $error("write strobe not one cycle");
  strobe_only_a: assert property (
    !nand_o.read_strobe_n |-> nand_o.we_n && nand_o.io_oe_n && !nand_o.ce_n)
    else $error("read strobe with bus driven");
  strobe_len_a: assert property (
    $fell(nand_o.read_strobe_n) |=> !nand_o.read_strobe_n ##1 !nand_o.read_strobe_n ##1 nand_o.read_strobe_n)
    else $error("read strobe low time");
  rd_hold_a: assert property (
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("stalled read word lost");
  busy_quiet_a: assert property (
    !rb_n && $past(!rb_n) && $past(!rb_n, 2) && $past(!rb_n, 3) |-> nand_o.we_n)
    else $error("write cycle while device busy");
  refuse_quiet_a: assert property (
    refused |-> nand_o.ce_n && !done)
    else $error("refused request touched pins");
  done_pulse_a: assert property (
    done |=> !done)
    else $error("done longer than one cycle");
  unprotect_a: assert property (
    !nand_o.ce_n |-> nand_o.wp_n)
    else $error("write protect active");
  cover property (done && fail);
  cover property (refused);
  cover property (rd_valid && !rd_ready);
  cover property ($fell(nand_o.read_strobe_n));
endmodule

bind nce_ctrl nce_ctrl_properties u_props (
  .clk(clk),
  .arst_n(arst_n),
  .rd_valid(rd_valid),
  .rd_ready(rd_ready),
  .rd_data(rd_data),
  .done(done),
  .fail(fail),
  .refused(refused),
  .nand_o(nand_o),
  .rb_n(rb_n)
);

// >>> tb/nce_flash_model.sv
// two-plane nand device model
`timescale 1ns/1ns
module nce_flash_model (
  input wire nce_pkg::nce_pins_s pins,
  output logic [7:0] io_in,
  output logic rb_n
);
  logic [7:0] mem [int];
  logic [7:0] pbuf [2][2112];
  logic [7:0] ab [5];
  logic [7:0] cmd, dout, stuck, d;
  logic [16:0] row;
  logic [11:0] col;
  logic [16:0] prow [$];
  logic [16:0] erow [$];
  logic stat_m, loaded, fail_q;
  int na, k, busy_ns;
  int ks [$];
  function automatic int key(logic [16:0] r, logic [11:0] c);
    return int'({r, c});
  endfunction
  task automatic hold(int ns);
    rb_n = 1'b0;
    #(ns);
    rb_n = 1'b1;
  endtask
  initial begin
    rb_n = 1'b1;
    dout = 8'h00;
    stuck = 8'h00;
    cmd = 8'h00;
    stat_m = 1'b0;
    loaded = 1'b0;
    fail_q = 1'b0;
    na = 0;
    busy_ns = 1500;
  end
  assign io_in = (!pins.ce_n && !pins.read_strobe_n) ? dout : ~dout;
  // ----------------------------------------
  // write strobe decode
  // ----------------------------------------
  always @(posedge pins.we_n) begin
    if (pins.ce_n === 1'b0 && pins.cle) begin
      cmd = pins.io_out;
      na = 0;
      stat_m = (cmd == 8'h70);
      case (cmd)
        8'h80: prow.delete();
        8'h30, 8'h35: begin
          for (int i = 0; i < 2112; i++) begin
            k = key(row, 12'(i));
            pbuf[row[6]][i] = mem.exists(k) ? mem[k] : 8'hFF;
          end
          hold(busy_ns);
        end
        8'h11: hold(300);
        8'h10: if (loaded) begin
          fail_q = 1'b0;
          foreach (prow[p]) for (int i = 0; i < 2112; i++) begin
            k = key(prow[p], 12'(i));
            d = mem.exists(k) ? mem[k] : 8'hFF;
            fail_q |= |(d & ~pbuf[prow[p][6]][i] & stuck);
            mem[k] = d & (pbuf[prow[p][6]][i] | stuck);
          end
          prow.delete();
          loaded = 1'b0;
          stat_m = 1'b1;
          hold(busy_ns);
        end
        8'hD0: begin
          ks.delete();
          foreach (erow[e]) foreach (mem[j]) if (j[28:18] == erow[e][16:6]) ks.push_back(j);
          foreach (ks[j]) mem.delete(ks[j]);
          erow.delete();
          fail_q = 1'b0;
          stat_m = 1'b1;
          hold(busy_ns);
        end
        8'hFF: begin
          prow.delete();
          erow.delete();
          loaded = 1'b0;
          hold(100);
        end
        default: ;
      endcase
    end else if (pins.ce_n === 1'b0 && pins.ale && na < 5) begin
      ab[na] = pins.io_out;
      na++;
      if (cmd == 8'h60 && na == 3) erow.push_back({ab[2][0], ab[1], ab[0]});
      if (cmd != 8'h60 && na == 2) col = {ab[1][3:0], ab[0]};
      if (cmd != 8'h60 && na == 5) begin
        row = {ab[4][0], ab[3], ab[2]};
        if (cmd == 8'h80 || cmd == 8'h81) for (int i = 0; i < 2112; i++) pbuf[row[6]][i] = 8'hFF;
        if (cmd[7]) begin
          prow.push_back(row);
          loaded = 1'b1;
        end
      end
    end else if (pins.ce_n === 1'b0) begin
      pbuf[row[6]][col] = pins.io_out;
      col++;
    end
  end
  always @(negedge pins.read_strobe_n) if (pins.ce_n === 1'b0) begin
    if (stat_m) dout = {pins.wp_n, rb_n, 5'h00, fail_q};
    else begin
      dout = pbuf[row[6]][col];
      col++;
    end
  end
endmodule

// >>> tb/nce_ctrl_tb_top.sv
// self-checking bench of the nand controller
`timescale 1ns/1ns
module nce_ctrl_tb_top;
  logic clk, arst_n, req_valid, req_ready, wr_valid, wr_ready, rd_valid, rd_ready;
  logic busy, done, fail, refused, rb_n;
  logic [7:0] wr_data, rd_data, status, io_in, stk;
  nce_pkg::nce_req_s req;
  nce_pkg::nce_pins_s nand_o;
  logic [7:0] sh [int];
  logic [7:0] wq [$], rq [$];
  integer seed;
  int failures, compares, cyc, c, n, ks [$];
  logic [16:0] ra, rc, r0, r1;
  nce_ctrl dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .busy(busy), .done(done), .fail(fail), .refused(refused), .status(status),
    .nand_o(nand_o), .io_in(io_in), .rb_n(rb_n));
  nce_flash_model m (.pins(nand_o), .io_in(io_in), .rb_n(rb_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic int key(logic [16:0] r, logic [11:0] cl);
    return int'({r, cl});
  endfunction
  function automatic logic [7:0] exp_b(logic [16:0] r, logic [11:0] cl);
    return sh.exists(key(r, cl)) ? sh[key(r, cl)] : 8'hFF;
  endfunction
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // streams and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    if (wr_valid && wr_ready) void'(wq.pop_front());
    wr_valid <= wq.size() > 0;
    wr_data <= (wq.size() > 0) ? wq[0] : 8'($random(seed));
    if (rd_valid && rd_ready) rq.push_back(rd_data);
    rd_ready <= ($random(seed) & 3) != 0;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------
  // request helpers
  // ----------------------------------------
  task automatic op(nce_pkg::nce_op_e o, logic [11:0] cl, logic [16:0] r, logic [11:0] ln, logic rf);
    int t;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{o, cl, r, ln};
    @(negedge clk);
    for (t = 0; t < 1000 && !req_ready; t++) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk) chk_bit(busy, !rf);
    for (t = 0; t < 30000 && !(done || refused); t++) @(negedge clk);
    chk_bit(refused, rf);
    chk_bit(done, !rf);
  endtask
  task automatic prog(nce_pkg::nce_op_e o, logic [11:0] cl, logic [16:0] r, int ln, logic [7:0] msk);
    logic [7:0] d;
    for (int i = 0; i < ln; i++) begin
      d = 8'($random(seed)) & msk;
      wq.push_back(d);
      sh[key(r, cl + 12'(i))] = d | stk;
    end
    m.stuck = stk;
    m.busy_ns = 200 + ($random(seed) & 2047);
    op(o, cl, r, 12'(ln), 1'b0);
  endtask
  task automatic rd(nce_pkg::nce_op_e o, logic [11:0] cl, logic [16:0] r, int ln);
    int t;
    rq.delete();
    op(o, cl, r, 12'(ln), 1'b0);
    for (t = 0; t < 400 && rq.size() < ln; t++) @(negedge clk);
    chk_bit(rq.size() == ln, 1'b1);
    foreach (rq[i]) chk_byte(rq[i], exp_b(r, cl + 12'(i)));
  endtask
  task automatic ers(logic [16:0] r);
    ks.delete();
    foreach (sh[k]) if (k[28:18] == r[16:6]) ks.push_back(k);
    foreach (ks[j]) sh.delete(ks[j]);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h0569_f9fe;
    {arst_n, req_valid, wr_valid, rd_ready} = 4'h0;
    req = '0;
    wr_data = 8'h00;
    stk = 8'h00;
    {cyc, failures, compares} = '0;
    ra = 17'h0_0082;
    rc = 17'h0_0083;
    r0 = 17'h0_0100;
    r1 = 17'h0_0140;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    c = 1023 & $random(seed);
    n = 1 + (15 & $random(seed));
    prog(nce_pkg::OP_PROG, 12'(c), ra, n, 8'hFF);
    chk_byte(status & 8'hC1, 8'hC0);
    rd(nce_pkg::OP_READ, 12'(c), ra, n);
    rd(nce_pkg::OP_ROUT, 12'(c + 1), ra, 2);
    rd(nce_pkg::OP_ROUT, 12'd2111, ra, 1);
    op(nce_pkg::OP_CBREAD, 12'h000, ra, 12'h000, 1'b0);
    prog(nce_pkg::OP_RIN, 12'(c + n), ra, 1, 8'hFF);
    for (int i = 0; i < 2112; i++) if (sh.exists(key(ra, 12'(i)))) sh[key(rc, 12'(i))] = sh[key(ra, 12'(i))];
    prog(nce_pkg::OP_CBPROG, 12'(c + 1), rc, 2, 8'hFF);
    rd(nce_pkg::OP_READ, 12'(c), rc, n + 2);
    op(nce_pkg::OP_PROG, 12'h000, rc, 12'h001, 1'b1);
    op(nce_pkg::OP_PROG, 12'h000, 17'h0_0090, 12'h000, 1'b1);
    op(nce_pkg::OP_PROG_P2, 12'(c), r1, 12'h001, 1'b1);
    stk = 8'h01;
    prog(nce_pkg::OP_PROG_P1, 12'(c), r0, n, 8'hFE);
    op(nce_pkg::OP_READ, 12'(c), r0, 12'h001, 1'b1);
    prog(nce_pkg::OP_PROG_P2, 12'(c), r1, n, 8'hFE);
    chk_bit(fail, 1'b1);
    stk = 8'h00;
    rd(nce_pkg::OP_READ, 12'(c), r1, n);
    op(nce_pkg::OP_ERASE, 12'h000, ra, 12'h000, 1'b0);
    chk_bit(fail, 1'b0);
    ers(ra);
    rd(nce_pkg::OP_READ, 12'(c), rc, n);
    op(nce_pkg::OP_ERASE_P1, 12'h000, r0, 12'h000, 1'b0);
    op(nce_pkg::OP_ERASE, 12'h000, r1, 12'h000, 1'b0);
    ers(r0);
    ers(r1);
    rd(nce_pkg::OP_READ, 12'(c), r0, n);
    for (int p = 0; p < 3; p++) begin
      c = 2047 & $random(seed);
      n = 1 + (31 & $random(seed));
      prog(nce_pkg::OP_PROG, 12'(c), r0 + 17'(p), n, 8'hFF);
      rd(nce_pkg::OP_READ, 12'(c), r0 + 17'(p), n);
    end
    op(nce_pkg::OP_STATUS, 12'h000, 17'h0_0000, 12'h000, 1'b0);
    chk_byte(status, 8'hC0);
    op(nce_pkg::OP_RESET, 12'h000, 17'h0_0000, 12'h000, 1'b0);
    final_report();
  end
endmodule
